// ===== hw/pwsc_consts.vh
// Constants for the peripheral window select control block.
// Included by the design files; holds only defines.
`ifndef PWSC_CONSTS_VH
`define PWSC_CONSTS_VH

// APB byte offsets of the local registers
`define PWSC_OFF_STC        12'h000
`define PWSC_OFF_SYSCTL     12'h004
`define PWSC_OFF_STATUS     12'h008
`define PWSC_OFF_CPUADDR    12'h00c
`define PWSC_OFF_ROUTE      12'h010

// Field positions of serial_timer_control
`define PWSC_BIT_XBUF       7
`define PWSC_BIT_RATE_HI    6
`define PWSC_BIT_RATE_LO    5
`define PWSC_BIT_I2CWIN     4
`define PWSC_BIT_FLASHWIN   3
`define PWSC_BIT_RSVD       2
`define PWSC_BIT_TCLK_HI    1
`define PWSC_BIT_TCLK_LO    0

// Field position of the host window bit in the system control word
`define PWSC_BIT_HOSTWIN    1

// Reset values
`define PWSC_RST_STC        8'h00
`define PWSC_RST_SYSCTL     8'h00
`define PWSC_RST_ADDR       24'h000000

// Window base addresses, low 16 bits of the CPU address
`define PWSC_WIN_PDN_LO     16'hff80
`define PWSC_WIN_PDN_HI     16'hff87
`define PWSC_WIN_SER_A_LO   16'hff88
`define PWSC_WIN_SER_A_HI   16'hff89
`define PWSC_WIN_SER_B_LO   16'hff8e
`define PWSC_WIN_SER_B_HI   16'hff8f
`define PWSC_WIN_I2C0_A_LO  16'hffd8
`define PWSC_WIN_I2C0_A_HI  16'hffd9
`define PWSC_WIN_I2C0_B_LO  16'hffde
`define PWSC_WIN_I2C0_B_HI  16'hffdf
`define PWSC_WIN_TMR_A_LO   16'hfff0
`define PWSC_WIN_TMR_A_HI   16'hfff7
`define PWSC_WIN_TMR_B_LO   16'hfffc
`define PWSC_WIN_TMR_B_HI   16'hffff

// Address space sizes: mode 2 uses 24 address bits, mode 3 uses 16
`define PWSC_ABITS_ADV      5'd24
`define PWSC_ABITS_NORM     5'd16
// Highest reachable byte in mode 3 (56 kbytes usable of 64)
`define PWSC_NORM_TOP       16'hdfff

// Route codes, one-hot
`define PWSC_RT_NONE        8'h00
`define PWSC_RT_PDN         8'h01
`define PWSC_RT_FLASH       8'h02
`define PWSC_RT_SER1        8'h04
`define PWSC_RT_I2C1        8'h08
`define PWSC_RT_I2C0        8'h10
`define PWSC_RT_TMR8        8'h20
`define PWSC_RT_KEYB        8'h40
`define PWSC_RT_MEM         8'h80

`endif

// ===== hw/pwsc_decode.v
// Window decoder: maps a CPU address to a one-hot register group.
// Assumes the select bits are stable for the access being decoded.
`timescale 1ns/10ps
`include "pwsc_consts.vh"

module pwsc_decode (
  // Address and mode
  input  wire [23:0] addr,
  input  wire        adv_mode,
  // Window select bits
  input  wire        i2c_window_enable,
  input  wire        flash_window_enable,
  input  wire        host_window_enable,
  // Result
  output reg  [7:0]  route
);

  wire        in_page;
  wire [15:0] a16;

  // Register page sits at the top of either address space
  assign a16     = addr[15:0];
  assign in_page = adv_mode ? (addr[23:16] == 8'hff) : 1'b1;

  // Window decode
  always @* begin
    route = `PWSC_RT_NONE;
    if (!in_page) begin
      route = `PWSC_RT_MEM; // [R10]
    end else if (a16 >= `PWSC_WIN_PDN_LO && a16 <= `PWSC_WIN_PDN_HI) begin
      route = flash_window_enable ? `PWSC_RT_FLASH : `PWSC_RT_PDN; // [R6] [R7]
    end else if ((a16 >= `PWSC_WIN_SER_A_LO && a16 <= `PWSC_WIN_SER_A_HI) ||
                 (a16 >= `PWSC_WIN_SER_B_LO && a16 <= `PWSC_WIN_SER_B_HI)) begin
      route = i2c_window_enable ? `PWSC_RT_I2C1 : `PWSC_RT_SER1; // [R3] [R4]
    end else if ((a16 >= `PWSC_WIN_I2C0_A_LO && a16 <= `PWSC_WIN_I2C0_A_HI) ||
                 (a16 >= `PWSC_WIN_I2C0_B_LO && a16 <= `PWSC_WIN_I2C0_B_HI)) begin
      // Otherwise unclaimed here
      route = i2c_window_enable ? `PWSC_RT_I2C0 : `PWSC_RT_NONE; // [R5]
    end else if ((a16 >= `PWSC_WIN_TMR_A_LO && a16 <= `PWSC_WIN_TMR_A_HI) ||
                 (a16 >= `PWSC_WIN_TMR_B_LO && a16 <= `PWSC_WIN_TMR_B_HI)) begin
      route = host_window_enable ? `PWSC_RT_KEYB : `PWSC_RT_TMR8; // [R13]
    end else if (adv_mode || a16 <= `PWSC_NORM_TOP) begin
      route = `PWSC_RT_MEM; // [R10] [R11]
    end
  end

endmodule // pwsc_decode

// ===== hw/pwsc_top.v
// Peripheral window select control: control register, window decode,
// pin mode, rate and timer clock selects. APB slave, 32-bit data.
// Assumes one clock pclk and an APB master that holds each request.
`timescale 1ns/10ps
`include "pwsc_consts.vh"

// What this block does
// R1: Bit 7 set makes port A bits 7..4 bus-driving pins, clear makes them normal pins.
// R2: Bits 6 and 5 join the I2C mode clock select field to pick the master transfer rate.
// R3: With the I2C window bit clear, FF88-FF89 and FF8E-FF8F reach serial channel one.
// R4: With the I2C window bit set, those areas reach I2C channel one instead.
// R5: With the I2C window bit set, I2C channel zero answers at FFD8-FFD9 and FFDE-FFDF.
// R6: With the flash window bit clear, FF80-FF87 reach power-down and peripheral control.
// R7: With the flash window bit set, FF80-FF87 reach the flash control registers.
// R8: Software keeps reserved bit 2 at zero; it resets to zero.
// R9: Bits 1 and 0 join the timer control clock select field to pick the counter clock.
// R10: Mode 2 gives a 16-Mbyte address space with on-chip ROM enabled.
// R11: Mode 3 gives a 64-Kbyte space with ROM enabled, 56 kbytes reachable.
// R12: A written select bit takes effect from the very next bus access.
// R13: The host window bit swaps FFF0-FFF7 and FFFC-FFFF between timers and keyboard.
module pwsc_top (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Operating mode strap: 1 is mode 2, 0 is mode 3
  input  wire        mode_adv,
  // Field selects from the I2C mode and timer control registers
  input  wire [2:0]  i2c_mode_clock_select_field,
  input  wire [2:0]  timer_control_clock_select_field,
  // Port A upper bits
  output reg         port_a_upper_bits_bus_drive,
  // Selected rate and clock codes
  output reg  [4:0]  i2c_rate_code,
  output reg  [4:0]  timer_clock_code,
  // Mode outputs
  output reg         rom_enable,
  output reg  [4:0]  addr_space_bits,
  // Routed group for the latched CPU address
  output reg  [7:0]  route_q
);

  reg  [7:0]  stc_q;
  reg  [7:0]  stc_d;
  reg  [7:0]  sysctl_q;
  reg  [23:0] cpu_addr_q;
  reg         adv_q;
  reg         strap_done_q;
  reg  [31:0] rd_d;
  reg         err_d;
  wire        wr_en;
  wire        rd_en;
  wire        acc;
  wire [7:0]  route_w;
  wire [7:0]  stc_next;
  wire [7:0]  sys_next;
  wire [23:0] addr_next;

  // Single access cycle: answer in the first access phase
  assign acc   = psel & penable;
  assign wr_en = acc & pwrite;
  assign rd_en = acc & ~pwrite;

  // Bypass write data so the decode sees the new bits at once [R12]
  assign stc_next  = (wr_en && paddr == `PWSC_OFF_STC) ? pwdata[7:0] : stc_q;
  assign sys_next  = (wr_en && paddr == `PWSC_OFF_SYSCTL) ? pwdata[7:0] : sysctl_q;
  assign addr_next = (wr_en && paddr == `PWSC_OFF_CPUADDR) ? pwdata[23:0] : cpu_addr_q;

  // Window decode of the CPU address
  pwsc_decode u_dec (
    .addr                (addr_next),
    .adv_mode            (adv_q),
    .i2c_window_enable   (stc_next[`PWSC_BIT_I2CWIN]),
    .flash_window_enable (stc_next[`PWSC_BIT_FLASHWIN]),
    .host_window_enable  (sys_next[`PWSC_BIT_HOSTWIN]),
    .route               (route_w)
  );

  // Control register next value; reserved bit kept at zero
  always @* begin
    stc_d = stc_q;
    if (wr_en && paddr == `PWSC_OFF_STC) begin
      stc_d = pwdata[7:0];
      stc_d[`PWSC_BIT_RSVD] = 1'b0; // [R8]
    end
  end

  // Register storage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stc_q      <= `PWSC_RST_STC;
      sysctl_q   <= `PWSC_RST_SYSCTL;
      cpu_addr_q <= `PWSC_RST_ADDR;
    end else begin
      stc_q <= stc_d; // [R12]
      if (wr_en && paddr == `PWSC_OFF_SYSCTL) begin
        sysctl_q <= pwdata[7:0];
      end
      if (wr_en && paddr == `PWSC_OFF_CPUADDR) begin
        cpu_addr_q <= pwdata[23:0];
      end
    end
  end

  // Mode strap caught once after reset release, never under reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adv_q        <= 1'b0;
      strap_done_q <= 1'b0;
    end else if (!strap_done_q) begin
      adv_q        <= mode_adv;
      strap_done_q <= 1'b1;
    end
  end

  // Read mux
  always @* begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    case (paddr)
      `PWSC_OFF_STC:     rd_d = {24'h000000, stc_q};
      `PWSC_OFF_SYSCTL:  rd_d = {24'h000000, sysctl_q};
      `PWSC_OFF_STATUS:  rd_d = {27'h0000000, strap_done_q, adv_q, 3'h0};
      `PWSC_OFF_CPUADDR: rd_d = {8'h00, cpu_addr_q};
      `PWSC_OFF_ROUTE:   rd_d = {24'h000000, route_q};
      default:           err_d = 1'b1;
    endcase
  end

  // APB answer, zero wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & err_d;
      if (psel && !penable && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  // Derived control outputs, all registered
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_upper_bits_bus_drive <= 1'b0;
      i2c_rate_code               <= 5'h00;
      timer_clock_code            <= 5'h00;
      rom_enable                  <= 1'b0;
      addr_space_bits             <= 5'h00;
      route_q                     <= `PWSC_RT_NONE;
    end else begin
      port_a_upper_bits_bus_drive <= stc_d[`PWSC_BIT_XBUF]; // [R1]
      i2c_rate_code    <= {stc_d[`PWSC_BIT_RATE_HI], stc_d[`PWSC_BIT_RATE_LO],
                           i2c_mode_clock_select_field}; // [R2]
      timer_clock_code <= {stc_d[`PWSC_BIT_TCLK_HI], stc_d[`PWSC_BIT_TCLK_LO],
                           timer_control_clock_select_field}; // [R9]
      rom_enable       <= strap_done_q; // [R10] [R11]
      // Held at zero until the strap is caught, so no stale mode is shown
      addr_space_bits  <= !strap_done_q ? 5'h00 :
                          (adv_q ? `PWSC_ABITS_ADV : `PWSC_ABITS_NORM); // [R10] [R11]
      route_q          <= route_w; // [R3] [R4] [R5] [R6] [R7] [R12] [R13]
    end
  end

endmodule // pwsc_top

// ===== tb/pwsc_checker.sv
// Checker for the window select block: bus answer, control bits, routes.
// Sees only the top-level ports; bound from the testbench top.
`timescale 1ns/10ps
module pwsc_checker (
  // Bus
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Mode and derived outputs
  input logic        mode_adv,
  input logic        port_a_upper_bits_bus_drive,
  input logic [4:0]  i2c_rate_code,
  input logic [4:0]  timer_clock_code,
  input logic        rom_enable,
  input logic [4:0]  addr_space_bits,
  input logic [7:0]  route_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Completed access, and a completed write to the control register
  wire acc    = psel && penable && pready;
  wire wr_stc = acc && pwrite && paddr == 12'h000;
  // Shadow of the control bits, so routes are judged without internals
  logic [7:0] stc_q;
  always @(posedge pclk or negedge presetn)
    if (!presetn) stc_q <= 8'h00;
    else if (wr_stc) stc_q <= pwdata[7:0];
  property p_ans; psel && !penable |=> pready ##1 !pready; endproperty
  a_ans: assert property (p_ans) else $error("answer not one cycle long");
  property p_xbuf; wr_stc |=> port_a_upper_bits_bus_drive == $past(pwdata[7]); endproperty
  a_xbuf: assert property (p_xbuf) else $error("pin mode wrong");
  property p_rate; wr_stc |=> i2c_rate_code[4:3] == $past(pwdata[6:5]); endproperty
  a_rate: assert property (p_rate) else $error("rate bits wrong");
  property p_tclk; wr_stc |=> timer_clock_code[4:3] == $past(pwdata[1:0]); endproperty
  a_tclk: assert property (p_tclk) else $error("timer clock bits wrong");
  property p_ser; route_q == 8'h04 |-> !stc_q[4]; endproperty
  a_ser: assert property (p_ser) else $error("serial route with i2c bit");
  property p_i2c; route_q inside {8'h08, 8'h10} |-> stc_q[4]; endproperty
  a_i2c: assert property (p_i2c) else $error("i2c route without bit");
  property p_pdn; route_q == 8'h01 |-> !stc_q[3]; endproperty
  a_pdn: assert property (p_pdn) else $error("power-down route with flash bit");
  property p_fls; route_q == 8'h02 |-> stc_q[3]; endproperty
  a_fls: assert property (p_fls) else $error("flash route without bit");
  property p_rsvd; acc && !pwrite && paddr == 12'h000 |-> !prdata[2]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit reads one");
  property p_space;
    addr_space_bits != 5'h00 |-> rom_enable && addr_space_bits == (mode_adv ? 5'h18 : 5'h10);
  endproperty
  a_space: assert property (p_space) else $error("space or rom wrong");
  c_i2c: cover property (route_q == 8'h08);
  c_fls: cover property (route_q == 8'h02);
  c_err: cover property (pslverr);
endmodule // pwsc_checker

// ===== tb/pwsc_cpu.sv
// CPU-side model: issues one register access at a time on the APB port.
// Assumes pclk runs and reset is released before the first call.
`timescale 1ns/10ps
module pwsc_cpu (
  // Clock
  input  logic        pclk,
  // Request
  output logic        psel,
  output logic        penable,
  output logic        pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input  logic [31:0] prdata,
  input  logic        pready,
  input  logic        pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // One transfer, held until pready; leaves an idle cycle after it
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d; // Released data must not look valid
    @(negedge pclk); // Let this edge's updates land
  endtask
endmodule // pwsc_cpu

// ===== tb/tb.sv
// Self-checking bench for the window select block and its CPU model.
// Assumes the design's constants header is on the include path.
`timescale 1ns/10ps
module tb;
  // Design ports
  logic        pclk, presetn, mode_adv, psel, penable, pwrite, pready, pslverr;
  logic        port_a_upper_bits_bus_drive, rom_enable, err;
  logic [2:0]  i2c_mode_clock_select_field, timer_control_clock_select_field;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0]  i2c_rate_code, timer_clock_code, addr_space_bits;
  logic [7:0]  route_q;
  int          miscompares, n_compared;
  pwsc_top uut (.*);
  pwsc_cpu cpu (.*);
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    cpu.xfer(1'b0, a, 32'h0, rd, err);
    chk(rd, exp, what);
  endtask
  // Reset for 3 cycles with the strap held; outputs valid two edges later
  task t_mode(input logic m, input logic [4:0] bits);
    if (presetn) @(posedge pclk); // Mid-run reset starts on a rising edge
    presetn <= 1'b0;
    mode_adv <= m;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    chk(addr_space_bits, bits, "space");
    chk(rom_enable, 1'b1, "rom");
    rdc(12'h000, 32'h0, "control reset");
    $display("done: mode %0d", m);
  endtask
  task t_bits;
    @(posedge pclk);
    i2c_mode_clock_select_field <= 3'h5;
    timer_control_clock_select_field <= 3'h2;
    cpu.xfer(1'b1, 12'h000, 32'h000000fb, rd, err);
    chk(port_a_upper_bits_bus_drive, 1'b1, "pins bus drive");
    chk(i2c_rate_code, 5'h1d, "rate set");
    chk(timer_clock_code, 5'h1a, "timer clock set");
    rdc(12'h000, 32'h000000fb, "control readback");
    cpu.xfer(1'b1, 12'h000, 32'h0, rd, err);
    chk(port_a_upper_bits_bus_drive, 1'b0, "pins normal");
    chk(i2c_rate_code, 5'h05, "rate clear");
    chk(timer_clock_code, 5'h02, "timer clock clear");
    $display("done: control bits");
  endtask
  // The control register is written last, after host bit and address, so the route shows the fresh setting
  task t_route(input logic h, input logic [7:0] s, input logic [23:0] a, input logic [7:0] e);
    cpu.xfer(1'b1, 12'h004, {30'h0, h, 1'b0}, rd, err);
    cpu.xfer(1'b1, 12'h00c, {8'h00, a}, rd, err);
    cpu.xfer(1'b1, 12'h000, {24'h0, s}, rd, err);
    chk(route_q, e, "route");
    rdc(12'h010, {24'h0, e}, "route reg");
    $display("done: route %h", a);
  endtask
  task t_err;
    cpu.xfer(1'b1, 12'h020, 32'h000000ff, rd, err);
    chk(err, 1'b1, "unmapped write");
    cpu.xfer(1'b0, 12'h020, 32'h0, rd, err);
    chk(err, 1'b1, "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    $display("done: unmapped");
  endtask
  task tally_and_finish;
    $display("compared %0d, wrong %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Hang guard, far above the under two hundred cycles the tests take
  initial begin
    repeat (5000) @(posedge pclk);
    miscompares++;
    tally_and_finish;
  end
  initial begin
    presetn = 1'b0;
    mode_adv = 1'b1;
    i2c_mode_clock_select_field = 3'h0;
    timer_control_clock_select_field = 3'h0;
    t_mode(1'b1, 5'h18);
    t_bits;
    t_route(1'b0, 8'h00, 24'hffff88, 8'h04);
    t_route(1'b0, 8'h10, 24'hffff8f, 8'h08);
    t_route(1'b0, 8'h10, 24'hffffd9, 8'h10);
    t_route(1'b0, 8'h00, 24'hffffde, 8'h00);
    t_route(1'b0, 8'h00, 24'hffff80, 8'h01);
    t_route(1'b0, 8'h08, 24'hffff87, 8'h02);
    t_route(1'b0, 8'h00, 24'hfffff7, 8'h20);
    t_route(1'b1, 8'h00, 24'hfffffc, 8'h40);
    t_route(1'b0, 8'h00, 24'h000100, 8'h80);
    t_err;
    t_mode(1'b0, 5'h10);
    t_route(1'b0, 8'h00, 24'h00e000, 8'h00);
    t_route(1'b0, 8'h00, 24'h000100, 8'h80);
    tally_and_finish;
  end
endmodule // tb
bind pwsc_top pwsc_checker chk_i (.*);
